// ===== core/ddr2_burst_port.sv
// two-word burst double-data-rate memory port, sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module ddr2_burst_port
    import ddr2_burst_pkg::*;
#(
    parameter int LOCK_CYCLES_P = LOCK_CYCLES,
    parameter int STOP_CYCLES_P = STOP_CYCLES
) (
    // system clock and reset
    input  wire logic              CLK,
    input  wire logic              RST,
    // link clocks
    input  wire logic              IN_CLK,
    input  wire logic              IN_CLK_N,
    input  wire logic              OUT_CLK,
    input  wire logic              OUT_CLK_N,
    // access controls
    input  wire logic              LOAD_STROBE_N,
    input  wire logic              READ_SELECT,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic              PLL_BYPASS_N,
    // write data
    input  wire logic [DATA_W-1:0] DATA_IN,
    input  wire logic [LANE_N-1:0] LANE_ENABLE_N,
    // read data
    output logic      [DATA_W-1:0] DATA_OUT,
    output logic                   DATA_OE_N,
    // echo clocks
    output logic                   ECHO_STROBE,
    output logic                   ECHO_STROBE_N,
    // status
    output logic                   PLL_LOCKED,
    output logic                   SINGLE_CLOCK,
    output logic                   IMPEDANCE_UPDATE
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    localparam int PIN_W = 7 + ADDR_W + DATA_W + LANE_N;

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [3:0]       clk_prev;

    assign pin_raw = {IN_CLK, IN_CLK_N, OUT_CLK, OUT_CLK_N, LOAD_STROBE_N,
                      READ_SELECT, PLL_BYPASS_N, ADDR, DATA_IN,
                      LANE_ENABLE_N};

    // control and data ride the same two stages as the clocks, so an edge
    // seen on the clocks lines up with the values present at that edge
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pin_s1   <= '0;
            pin_s2   <= '0;
            clk_prev <= 4'h0;
        end else begin
            pin_s1   <= pin_raw;
            pin_s2   <= pin_s1;
            clk_prev <= pin_s2[PIN_W-1 -: 4];
        end
    end

    wire              k_s     = pin_s2[PIN_W-1];
    wire              kn_s    = pin_s2[PIN_W-2];
    wire              c_s     = pin_s2[PIN_W-3];
    wire              cn_s    = pin_s2[PIN_W-4];
    wire              ld_n_s  = pin_s2[PIN_W-5];
    wire              rd_s    = pin_s2[PIN_W-6];
    wire              pll_on  = pin_s2[PIN_W-7];
    wire [ADDR_W-1:0] addr_s  = pin_s2[DATA_W+LANE_N +: ADDR_W];
    wire [DATA_W-1:0] din_s   = pin_s2[LANE_N +: DATA_W];
    wire [LANE_N-1:0] lane_en = ~pin_s2[LANE_N-1:0];

    wire k_rise  = k_s & ~clk_prev[3];
    wire kn_rise = kn_s & ~clk_prev[2];
    wire c_rise  = c_s & ~clk_prev[1];
    wire cn_rise = cn_s & ~clk_prev[0];

    // ------------------------------------------------------------------
    // single-clock strap, caught once after reset release
    // ------------------------------------------------------------------
    logic [1:0] strap_wait;
    logic       single_clock;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            strap_wait   <= 2'h0;
            single_clock <= 1'b0;
        end else if (strap_wait != STRAP_WAIT) begin
            strap_wait   <= strap_wait + 2'h1;
            single_clock <= c_s & cn_s;
        end
    end

    assign SINGLE_CLOCK = single_clock;

    wire out_pos_rise = single_clock ? k_rise : c_rise;
    wire out_neg_rise = single_clock ? kn_rise : cn_rise;
    wire first_edge   = pll_on ? out_neg_rise : out_pos_rise;
    wire second_edge  = pll_on ? out_pos_rise : out_neg_rise;

    // ------------------------------------------------------------------
    // echo clocks
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ECHO_STROBE   <= 1'b0;
            ECHO_STROBE_N <= 1'b0;
        end else begin
            ECHO_STROBE   <= single_clock ? k_s : c_s;
            ECHO_STROBE_N <= single_clock ? kn_s : cn_s;
        end
    end

    // ------------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------------
    // load high on an edge starts nothing
    wire start_read  = k_rise & ~ld_n_s & rd_s;
    wire start_write = k_rise & ~ld_n_s & ~rd_s;

    // ------------------------------------------------------------------
    // word array
    // ------------------------------------------------------------------
    logic              mem_wr_en;
    logic [ADDR_W-1:0] mem_wr_addr;
    logic [DATA_W-1:0] mem_wr_data;
    logic [LANE_N-1:0] mem_wr_lane;
    logic [ADDR_W-1:0] mem_rd_addr;
    logic [DATA_W-1:0] mem_rd_data;

    sram_word_array #(
        .AW (ADDR_W),
        .DW (DATA_W),
        .LW (LANE_W),
        .LN (LANE_N)
    ) u_array (
        .clk     (CLK),
        .wr_en   (mem_wr_en),
        .wr_addr (mem_wr_addr),
        .wr_data (mem_wr_data),
        .wr_lane (mem_wr_lane),
        .rd_addr (mem_rd_addr),
        .rd_data (mem_rd_data)
    );

    // ------------------------------------------------------------------
    // write collection and posted write
    // ------------------------------------------------------------------
    logic              wr_armed;
    logic [ADDR_W-1:0] wr_addr_new;
    logic              have0;
    logic [ADDR_W-1:0] cur_addr;
    logic [DATA_W-1:0] cur_d0;
    logic [LANE_N-1:0] cur_en0;
    posted_type        posted;
    logic [1:0]        commit_step;

    // a new write may start on the same edge that takes the previous
    // write's first word, so the address moves to a second stage there
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wr_armed    <= 1'b0;
            wr_addr_new <= '0;
        end else if (k_rise) begin
            wr_armed    <= start_write;
            if (start_write) wr_addr_new <= addr_s;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            have0    <= 1'b0;
            cur_addr <= '0;
            cur_d0   <= '0;
            cur_en0  <= '0;
        end else if (k_rise && wr_armed) begin
            have0    <= 1'b1;
            cur_addr <= wr_addr_new;
            cur_d0   <= din_s;
            cur_en0  <= lane_en;
        end else if (kn_rise) begin
            have0    <= 1'b0;
        end
    end

    // data and lanes are looked at only while a write is collecting
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            posted <= '0;
        end else if (kn_rise && have0) begin
            posted <= '{valid: 1'b1, addr: cur_addr, d0: cur_d0,
                        d1: din_s, en0: cur_en0,
                        en1: lane_en};
        end
    end

    // the held write reaches the array only when the next write starts
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            commit_step <= COMMIT_IDLE;
        end else if (start_write && posted.valid) begin
            commit_step <= COMMIT_FIRST;
        end else if (commit_step == COMMIT_FIRST) begin
            commit_step <= COMMIT_SECOND;
        end else begin
            commit_step <= COMMIT_IDLE;
        end
    end

    wire commit_second = (commit_step == COMMIT_SECOND);

    assign mem_wr_en   = (commit_step != COMMIT_IDLE);
    assign mem_wr_addr = {posted.addr[ADDR_W-1:1],
                          posted.addr[0] ^ commit_second};
    assign mem_wr_data = commit_second ? posted.d1 : posted.d0;
    assign mem_wr_lane = commit_second ? posted.en1 : posted.en0;

    // ------------------------------------------------------------------
    // read fetch with forwarding
    // ------------------------------------------------------------------
    logic              rd_armed;
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] fetch_base;
    logic [1:0]        fetch_cnt;
    logic [DATA_W-1:0] fetch_first;
    burst_type         burst;
    logic              burst_valid;
    logic              burst_take;

    // posted words overlay the array word lane by lane
    function automatic logic [DATA_W-1:0] forward(
        input logic [DATA_W-1:0] word,
        input posted_type        p,
        input logic [ADDR_W-1:0] a
    );
        logic              sel;
        logic [DATA_W-1:0] pd;
        logic [LANE_N-1:0] pe;
        logic [DATA_W-1:0] res;
        sel = a[0] ^ p.addr[0];
        pd  = sel ? p.d1 : p.d0;
        pe  = sel ? p.en1 : p.en0;
        res = word;
        if (p.valid && p.addr[ADDR_W-1:1] == a[ADDR_W-1:1]) begin
            for (int i = 0; i < LANE_N; i++) begin
                if (pe[i]) res[i*LANE_W +: LANE_W] = pd[i*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction : forward

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_armed <= 1'b0;
            rd_addr  <= '0;
        end else if (start_read) begin
            rd_armed <= 1'b1;
            rd_addr  <= addr_s;
        end else if (kn_rise) begin
            rd_armed <= 1'b0;
        end
    end

    // fetch runs after the falling edge, when any write ahead of it has
    // its last word held, so forwarding always sees the newest data
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            fetch_cnt   <= FETCH_IDLE;
            fetch_base  <= '0;
            fetch_first <= '0;
        end else if (kn_rise && rd_armed) begin
            fetch_cnt   <= FETCH_FIRST;
            fetch_base  <= rd_addr;
        end else begin
            fetch_cnt <= (fetch_cnt == FETCH_MERGE) ? FETCH_IDLE
                                                    : fetch_cnt + 2'h1;
            if (fetch_cnt == FETCH_SECOND) fetch_first <= mem_rd_data;
            if (fetch_cnt == FETCH_IDLE) fetch_cnt <= FETCH_IDLE;
        end
    end

    assign mem_rd_addr = {fetch_base[ADDR_W-1:1],
                          fetch_base[0] ^ (fetch_cnt == FETCH_SECOND)};

    wire [ADDR_W-1:0] base_pair = {fetch_base[ADDR_W-1:1], ~fetch_base[0]};
    wire fetch_done = (fetch_cnt == FETCH_MERGE);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            burst <= '0;
        end else if (fetch_done) begin
            burst.first  <= forward(fetch_first, posted, fetch_base);
            burst.second <= forward(mem_rd_data, posted, base_pair);
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            burst_valid <= 1'b0;
        end else if (fetch_done) begin
            burst_valid <= 1'b1;
        end else if (burst_take) begin
            burst_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // output sequencer
    // ------------------------------------------------------------------
    out_state_type     state;
    out_state_type     next_state;
    logic [DATA_W-1:0] second_hold;

    assign burst_take = burst_valid && first_edge &&
                        (state == OUT_FIRST || state == OUT_TAIL);

    always_comb begin
        next_state = state;
        case (state)
            OUT_IDLE:   if (burst_valid) next_state = OUT_FIRST;
            OUT_FIRST:  if (first_edge) next_state = OUT_SECOND;
            OUT_SECOND: if (second_edge) next_state = OUT_TAIL;
            OUT_TAIL: begin
                if (burst_take) next_state = OUT_SECOND;
                else if (out_pos_rise && !burst_valid) next_state = OUT_IDLE;
                else if (burst_valid) next_state = OUT_FIRST;
            end
            default:    next_state = OUT_IDLE;
        endcase
    end

    // a started burst always runs to its second word
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state       <= OUT_IDLE;
            DATA_OUT    <= '0;
            DATA_OE_N   <= 1'b1;
            second_hold <= '0;
        end else begin
            state <= next_state;
            if (burst_take) begin
                DATA_OUT    <= burst.first;
                DATA_OE_N   <= 1'b0;
                second_hold <= burst.second;
            end else if (state == OUT_SECOND && second_edge) begin
                DATA_OUT    <= second_hold;
            end else if (state == OUT_TAIL && next_state == OUT_IDLE) begin
                DATA_OE_N   <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // pll lock and impedance tracking
    // ------------------------------------------------------------------
    logic [7:0]       gap_cnt;
    logic [15:0]      lock_cnt;
    logic [IMP_W-1:0] imp_cnt;

    wire clk_stopped = (gap_cnt >= 8'(STOP_CYCLES_P));

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            gap_cnt <= 8'h00;
        end else if (k_rise || kn_rise) begin
            gap_cnt <= 8'h00;
        end else if (!clk_stopped) begin
            gap_cnt <= gap_cnt + 8'h01;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            lock_cnt <= 16'h0000;
        end else if (clk_stopped || !pll_on) begin
            lock_cnt <= 16'h0000;
        end else if (lock_cnt != 16'(LOCK_CYCLES_P)) begin
            lock_cnt <= lock_cnt + 16'h0001;
        end
    end

    assign PLL_LOCKED = (lock_cnt == 16'(LOCK_CYCLES_P));

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            imp_cnt          <= '0;
            IMPEDANCE_UPDATE <= 1'b0;
        end else begin
            IMPEDANCE_UPDATE <= k_rise && (imp_cnt == IMP_W'(IMP_PERIOD - 1));
            if (k_rise) imp_cnt <= imp_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    AST_READ_LATCH: assert property (
        start_read |=> rd_armed && rd_addr == $past(addr_s))
        else $error("read start did not latch the address");
    AST_WRITE_LATCH: assert property (
        start_write |=> wr_armed && wr_addr_new == $past(addr_s))
        else $error("write start did not latch the address");
    AST_SECOND_ADDR: assert property (
        fetch_cnt == FETCH_SECOND |->
            mem_rd_addr == {fetch_base[ADDR_W-1:1], ~fetch_base[0]})
        else $error("second burst word not at inverted lsb");
    AST_FIRST_OUT: assert property (
        burst_take |=> !DATA_OE_N && DATA_OUT == $past(burst.first))
        else $error("first word not driven on its edge");
    AST_PLL_EDGE: assert property (
        pll_on && $fell(DATA_OE_N) |-> $past(out_neg_rise))
        else $error("pll mode first word not on negative edge");
    AST_LEGACY_EDGE: assert property (
        !pll_on && $fell(DATA_OE_N) |-> $past(out_pos_rise))
        else $error("bypass mode first word not on positive edge");
    AST_FLOAT: assert property (
        state == OUT_TAIL && out_pos_rise && !burst_valid |=> DATA_OE_N)
        else $error("outputs not released after last word");
    AST_POWERUP: assert property (
        state == OUT_IDLE |-> DATA_OE_N)
        else $error("outputs driven while idle");
    AST_POSTED: assert property (
        kn_rise && have0 |=> posted.valid && posted.d1 == $past(din_s))
        else $error("second write word not held");
    AST_IGNORE: assert property (
        !(kn_rise && have0) |=> $stable(posted))
        else $error("held write changed without a write");
    AST_COMMIT: assert property (
        start_write && posted.valid |=>
            mem_wr_en && mem_wr_addr == posted.addr ##1
            mem_wr_en && mem_wr_lane == posted.en1 ##1 !mem_wr_en)
        else $error("held write not committed as two words");
    AST_FETCH: assert property (
        kn_rise && rd_armed |-> ##3 fetch_done ##1 burst_valid)
        else $error("read burst not fetched in time");
    AST_IMPEDANCE: assert property (
        k_rise && imp_cnt == IMP_W'(IMP_PERIOD - 1) |=> IMPEDANCE_UPDATE)
        else $error("impedance update missed");

endmodule : ddr2_burst_port
`default_nettype wire

// ===== core/ddr2_burst_pkg.sv
// constants, carrier types and states for the two-word burst memory port
package ddr2_burst_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int DATA_W    = 18;
    localparam int LANE_W    = 9;
    localparam int LANE_N    = 2;
    localparam int ADDR_W    = 21;
    localparam int BURST_LEN = 2;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int LOCK_TIME_NS  = 20000;
    localparam int LOCK_CYCLES   =
        (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STOP_TIME_NS  = 30;
    localparam int STOP_CYCLES   =
        (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IMP_PERIOD    = 1024;
    localparam int IMP_W         = 10;

    // ------------------------------------------------------------------
    // reset values and sequence counts
    // ------------------------------------------------------------------
    localparam logic [1:0] STRAP_WAIT     = 2'h3;
    localparam logic [1:0] FETCH_IDLE     = 2'h0;
    localparam logic [1:0] FETCH_FIRST    = 2'h1;
    localparam logic [1:0] FETCH_SECOND   = 2'h2;
    localparam logic [1:0] FETCH_MERGE    = 2'h3;
    localparam logic [1:0] COMMIT_IDLE    = 2'h0;
    localparam logic [1:0] COMMIT_FIRST   = 2'h1;
    localparam logic [1:0] COMMIT_SECOND  = 2'h2;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] first;
        logic [DATA_W-1:0] second;
    } burst_type;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] d0;
        logic [DATA_W-1:0] d1;
        logic [LANE_N-1:0] en0;
        logic [LANE_N-1:0] en1;
    } posted_type;

    typedef enum logic [1:0] {
        OUT_IDLE   = 2'b00,
        OUT_FIRST  = 2'b01,
        OUT_SECOND = 2'b10,
        OUT_TAIL   = 2'b11
    } out_state_type;

endpackage : ddr2_burst_pkg

// ===== core/sram_word_array.sv
// word array with lane-gated write port and registered read port
`timescale 1ns/1ps
`default_nettype none
module sram_word_array
    import ddr2_burst_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W,
    parameter int LW = LANE_W,
    parameter int LN = LANE_N
) (
    // clock
    input  wire logic          clk,
    // write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [LN-1:0] wr_lane,
    // read port
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // untouched lanes keep their stored bits
    always_ff @(posedge clk) begin
        for (int i = 0; i < LN; i++) begin
            if (wr_en && wr_lane[i]) begin
                mem[wr_addr][i*LW +: LW] <= wr_data[i*LW +: LW];
            end
        end
    end

    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end

endmodule : sram_word_array
`default_nettype wire

// ===== testbench/ctrl_clock_model.sv
// link clock source standing in for the memory controller
`timescale 1ns/1ps
`default_nettype none
module ctrl_clock_model (
    // link clocks
    output var logic k,
    output logic     k_n,
    output logic     c,
    output logic     c_n
);
    // never slowed or stopped, so the pll locks once and stays locked until bypassed
    initial begin
        k = 1'b0;
        #3.3;
        forever #62.5 k = ~k;
    end
    // zero skew output pair; never both high, so no single-clock strap
    assign k_n = ~k;
    assign c   = k;
    assign c_n = ~k;
endmodule : ctrl_clock_model
`default_nettype wire

// ===== testbench/tb_ddr2_burst_port.sv
// self-checking bench for the two-word burst memory port
`timescale 1ns/1ps
`default_nettype none
module tb_ddr2_burst_port
    import ddr2_burst_pkg::*;
;
    logic              clk, rst, load_n, sel, byp_n, oe_n, echo, echo_n;
    logic              locked, single, imp;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din, dout;
    logic [LANE_N-1:0] lane_n;
    wire logic         k, k_n, c, c_n;
    int                errors, n_tests, cyc;
    // first and second word edges swap with the pll bypassed
    wire logic         f = byp_n ? c_n : c;
    wire logic         s = byp_n ? c : c_n;

    ctrl_clock_model link (.k(k), .k_n(k_n), .c(c), .c_n(c_n));
    ddr2_burst_port #(.LOCK_CYCLES_P(20), .STOP_CYCLES_P(30)) uut (
        .CLK(clk), .RST(rst), .IN_CLK(k), .IN_CLK_N(k_n),
        .OUT_CLK(c), .OUT_CLK_N(c_n), .LOAD_STROBE_N(load_n),
        .READ_SELECT(sel), .ADDR(addr), .PLL_BYPASS_N(byp_n),
        .DATA_IN(din), .LANE_ENABLE_N(lane_n), .DATA_OUT(dout),
        .DATA_OE_N(oe_n), .ECHO_STROBE(echo), .ECHO_STROBE_N(echo_n),
        .PLL_LOCKED(locked), .SINGLE_CLOCK(single),
        .IMPEDANCE_UPDATE(imp));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(string nm, logic [DATA_W-1:0] e, logic [DATA_W-1:0] v);
        n_tests++;
        if (v !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, v);
            errors++;
        end
    endtask : chk

    task automatic settle;
        repeat (8) @(posedge clk);
        #1;
    endtask : settle

    // inputs change 27.7 ns after a k rise, well clear of both sampling edges
    task automatic step;
        @(posedge k);
        repeat (6) @(posedge clk);
        #1;
    endtask : step

    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] w1,
                      logic [LANE_N-1:0] l1, logic [DATA_W-1:0] w2,
                      logic [LANE_N-1:0] l2);
        step;
        {load_n, sel, addr} = {2'h0, a};
        step;
        {load_n, din, lane_n} = {1'b1, w1, l1};
        step;
        {din, lane_n} = {w2, l2};
        step;
        // junk with lanes enabled must be ignored outside a write
        {din, lane_n} = {18'h3FFFF, 2'h0};
        $display("write %h done", a);
    endtask : wr

    task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e1,
                      logic [DATA_W-1:0] e2);
        step;
        {load_n, sel, addr} = {2'h1, a};
        step;
        load_n = 1'b1;
        repeat (byp_n ? 2 : 1) @(posedge f);
        settle;
        chk("first word", e1, dout);
        chk("oe during burst", '0, DATA_W'(oe_n));
        @(posedge s);
        settle;
        chk("second word", e2, dout);
        chk("echo strobe", DATA_W'(c), DATA_W'(echo));
        chk("echo strobe n", DATA_W'(c_n), DATA_W'(echo_n));
        @(posedge c);
        settle;
        chk("oe after burst", DATA_W'(1), DATA_W'(oe_n));
        $display("read %h done", a);
    endtask : rd

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            stop_test();
        end
    end

    initial begin
        {rst, load_n, sel, byp_n, addr, din, lane_n} = '1;
        {errors, n_tests, cyc} = '0;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        settle;
        chk("oe after reset", DATA_W'(1), DATA_W'(oe_n));
        chk("single clock", '0, DATA_W'(single));
        chk("impedance idle", '0, DATA_W'(imp));
        wr(21'h4, 18'h3FFFF, 2'h0, 18'h2AAAA, 2'h0);
        wr(21'h4, 18'h12345, 2'h3, 18'h0, 2'h3);
        // the lane-masked write stays held, so the reads below are forwarded
        wr(21'h5, 18'h0, 2'h2, 18'h0, 2'h1);
        rd(21'h4, 18'h001FF, 18'h2AA00);
        rd(21'h5, 18'h2AA00, 18'h001FF);
        chk("pll locked", DATA_W'(1), DATA_W'(locked));
        byp_n = 1'b0;
        rd(21'h5, 18'h2AA00, 18'h001FF);
        chk("pll unlocked", '0, DATA_W'(locked));
        stop_test();
    end
endmodule : tb_ddr2_burst_port
`default_nettype wire
